// ### dnpbs_regs.sv
// dnpbs_regs: apb register bank for ddc nco preset choice, channel binding,
// rational divisor and nco phase-start control
// assumes an apb master on pclk, link logic giving a same-clock lane-align
// lmfc pulse, and sysref plus preset pins arriving asynchronously
//
// The APB register port was left to the implementer.

`timescale 1ns/1ps

module dnpbs_regs
  import dnpbs_pkg::*;
(
  input  wire logic              pclk,                 // device clock
  input  wire logic              presetn,              // async reset, low
  input  wire logic              psel,                 // apb select
  input  wire logic              penable,              // apb access phase
  input  wire logic              pwrite,               // apb direction
  input  wire logic [ADDR_W-1:0] paddr,                // apb byte address
  input  wire logic [31:0]       pwdata,               // apb write data
  input  wire logic [3:0]        pstrb,                // apb byte lanes
  output logic      [31:0]       prdata,               // apb read data
  output logic                   pready,               // apb ready
  output logic                   pslverr,              // apb error
  input  wire logic [1:0]        preset_source_mode,   // from mode register
  input  wire logic [1:0]        ncoa_pins,            // ddc a preset pins
  input  wire logic [1:0]        ncob_pins,            // ddc b preset pins
  input  wire logic              sysref,               // sysref pin
  input  wire logic              lmfc_ila_start,       // lane-align lmfc
  input  wire logic              adc_a_power_down,     // adc a powered down
  input  wire logic              adc_b_power_down,     // adc b powered down
  output logic      [1:0]        ddc_a_preset_index,   // active ddc a preset
  output logic      [1:0]        ddc_b_preset_index,   // active ddc b preset
  output logic                   chan_a_source_select, // chan a from adc b
  output logic                   chan_b_source_select, // chan b from adc b
  output logic                   chan_a_power_down,    // chan a and link off
  output logic                   chan_b_power_down,    // chan b and link off
  output logic      [15:0]       rational_ref_divisor, // shared divisor
  output logic                   nco_phase_init,       // phase start pulse
  output logic                   sync_armed            // waiting for sysref
);

  // ****************************************************************
  // storage
  // ****************************************************************
  logic [7:0]  nco_preset_select;
  logic [7:0]  digital_channel_binding;
  logic [15:0] rational_nco_ref_divisor;
  logic [7:0]  nco_phase_sync_control;
  dnpbs_arm_t  arm_state;
  dnpbs_arm_t  next_arm;
  logic        sysref_prev;
  logic [4:0]  pin_stable;

  // ****************************************************************
  // decoding helpers
  // ****************************************************************
  // preset choice, shared by both ddcs; reserved mode keeps the register
  function automatic logic [1:0] pick_preset(
    input logic [1:0] mode,
    input logic [1:0] reg_field,
    input logic [1:0] own_pins,
    input logic [1:0] a_pins
  );
    logic [1:0] r;
    r = reg_field;
    case (mode)
      MODE_REGISTER:    r = reg_field;
      MODE_PIN_PAIRS:   r = own_pins;
      MODE_SHARED_PINS: r = a_pins;
      default:          r = reg_field;
    endcase
    return r;
  endfunction

  // a digital channel follows the power state of the adc it is bound to
  function automatic logic bound_down(
    input logic from_b,
    input logic pd_a,
    input logic pd_b
  );
    return from_b ? pd_b : pd_a;
  endfunction

  // ****************************************************************
  // apb decode
  // ****************************************************************
  wire logic             setup     = psel & ~penable;
  wire logic             access    = psel & penable & pready;
  wire logic             wr_en     = access & pwrite;
  wire logic [IDX_W-1:0] word_idx  = paddr[ADDR_W-1:2];
  wire logic             aligned   = (paddr[1:0] == 2'b00);
  wire logic             hit_sel   = aligned & (word_idx == IDX_PRESET_SELECT);
  wire logic             hit_bind  = aligned & (word_idx == IDX_CHAN_BIND);
  wire logic             hit_div   = aligned & (word_idx == IDX_REF_DIV);
  wire logic             hit_sync  = aligned & (word_idx == IDX_PHASE_SYNC);
  wire logic             hit_stat  = aligned & (word_idx == IDX_STATUS);
  wire logic             mapped    = hit_sel | hit_bind | hit_div |
                                     hit_sync | hit_stat;
  // status is read-only; writing it is flagged rather than silently lost
  wire logic             bus_err   = ~mapped | (pwrite & hit_stat);

  // write strobes, byte lane gated
  wire logic             wr_sel    = wr_en & hit_sel & pstrb[0];
  wire logic             wr_bind   = wr_en & hit_bind & pstrb[0];
  wire logic             wr_div_lo = wr_en & hit_div & pstrb[0];
  wire logic             wr_div_hi = wr_en & hit_div & pstrb[1];
  wire logic             wr_sync   = wr_en & hit_sync & pstrb[0];
  wire logic [7:0]       wd_lo     = pwdata[7:0];
  wire logic [7:0]       wd_hi     = pwdata[15:8];
  wire logic             wd_bit0   = pwdata[0];
  wire logic             wd_bit1   = pwdata[1];

  // ****************************************************************
  // read mux
  // ****************************************************************
  wire logic [7:0]  status_byte = {2'b00, chan_b_power_down,
                                   chan_a_power_down, ddc_b_preset_index,
                                   ddc_a_preset_index};
  wire logic [31:0] rd_word =
    hit_sel  ? {24'h000000, nco_preset_select}        :
    hit_bind ? {24'h000000, digital_channel_binding}  :
    hit_div  ? {16'h0000, rational_nco_ref_divisor}   :
    hit_sync ? {24'h000000, nco_phase_sync_control}   :
    hit_stat ? {23'h000000, sync_armed, status_byte}  :
               32'h00000000;

  // ****************************************************************
  // apb answer: one access cycle, no wait states
  // ****************************************************************
  // ready and data are captured in setup so they leave a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= setup;
      pslverr <= setup & bus_err;
      if (setup) begin
        prdata <= pwrite ? 32'h00000000 : rd_word;
      end
    end
  end

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  // reserved bits kept
  // whole bytes are stored; only the documented fields are decoded
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nco_preset_select       <= RST_PRESET_SELECT;
      digital_channel_binding <= RST_CHAN_BIND;
      nco_phase_sync_control  <= RST_PHASE_SYNC;
    end else begin
      if (wr_sel) begin
        nco_preset_select <= wd_lo;
      end
      if (wr_bind) begin
        digital_channel_binding <= wd_lo;
      end
      if (wr_sync) begin
        nco_phase_sync_control <= wd_lo;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rational_nco_ref_divisor <= RST_REF_DIV;
    end else begin
      if (wr_div_lo) begin
        rational_nco_ref_divisor[7:0] <= wd_lo;
      end
      if (wr_div_hi) begin
        rational_nco_ref_divisor[15:8] <= wd_hi;
      end
    end
  end

  assign chan_b_source_select = digital_channel_binding[BIT_CHAN_B_SRC];
  assign chan_a_source_select = digital_channel_binding[BIT_CHAN_A_SRC];
  assign rational_ref_divisor = rational_nco_ref_divisor;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  // preset pins may settle at different times; each bit is filtered on its own, so skew between bits still reaches pin_stable
  dnpbs_pin_sync #(
    .W (5)
  ) u_pin_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({sysref, ncob_pins, ncoa_pins}),
    .q       (pin_stable)
  );

  wire logic [1:0] pin_a       = pin_stable[1:0];
  wire logic [1:0] pin_b       = pin_stable[3:2];
  wire logic       sysref_lvl  = pin_stable[4];
  wire logic       sysref_rise = sysref_lvl & ~sysref_prev;

  // ****************************************************************
  // active preset and power-down
  // ****************************************************************
  wire logic [1:0] fld_a = nco_preset_select[DDC_A_LSB +: 2];
  wire logic [1:0] fld_b = nco_preset_select[DDC_B_LSB +: 2];
  wire logic [1:0] next_ddc_a = pick_preset(preset_source_mode, fld_a,
                                            pin_a, pin_a);
  wire logic [1:0] next_ddc_b = pick_preset(preset_source_mode, fld_b,
                                            pin_b, pin_a);
  wire logic next_pd_a = bound_down(chan_a_source_select,
                                    adc_a_power_down, adc_b_power_down);
  wire logic next_pd_b = bound_down(chan_b_source_select,
                                    adc_a_power_down, adc_b_power_down);

  // registered so datapath selects never see a decode glitch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ddc_a_preset_index <= 2'h0;
      ddc_b_preset_index <= 2'h0;
      chan_a_power_down  <= 1'b0;
      chan_b_power_down  <= 1'b0;
    end else begin
      ddc_a_preset_index <= next_ddc_a;
      ddc_b_preset_index <= next_ddc_b;
      chan_a_power_down  <= next_pd_a;
      chan_b_power_down  <= next_pd_b;
    end
  end

  // ****************************************************************
  // nco phase start
  // ****************************************************************
  wire logic wr_sync_zero = wr_sync & ~pwdata[BIT_SYNC_NEXT];
  wire logic wr_sync_one  = wr_sync & pwdata[BIT_SYNC_NEXT];
  wire logic ila_fire  = nco_phase_sync_control[BIT_SYNC_ILA] &
                         lmfc_ila_start;
  wire logic sref_fire = (arm_state == ARM_READY) & sysref_rise;

  // one shot per arm
  // a 1 alone never arms: the 0 must come first, so a stale 1 is harmless
  always_comb begin
    next_arm = arm_state;
    case (arm_state)
      ARM_IDLE: begin
        next_arm = wr_sync_zero ? ARM_PRIMED : ARM_IDLE;
      end
      ARM_PRIMED: begin
        next_arm = wr_sync_one ? ARM_READY : ARM_PRIMED;
      end
      ARM_READY: begin
        if (wr_sync_zero) begin
          next_arm = ARM_PRIMED;
        end else if (sysref_rise) begin
          next_arm = ARM_IDLE;
        end else begin
          next_arm = ARM_READY;
        end
      end
      default: begin
        next_arm = ARM_IDLE;
      end
    endcase
  end

  // state, edge history and the start pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arm_state      <= ARM_IDLE;
      sysref_prev    <= 1'b0;
      nco_phase_init <= 1'b0;
      sync_armed     <= 1'b0;
    end else begin
      arm_state      <= next_arm;
      sysref_prev    <= sysref_lvl;
      nco_phase_init <= ila_fire | sref_fire;
      sync_armed     <= (next_arm == ARM_READY);
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking dflt_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_ddc_b_reg;
    (preset_source_mode == MODE_REGISTER) |=>
      (ddc_b_preset_index == $past(fld_b));
  endproperty
  a_ddc_b_reg: assert property (p_ddc_b_reg)
    else $error("ddc b preset does not follow register field");

  property p_ddc_a_reg;
    (preset_source_mode == MODE_REGISTER) |=>
      (ddc_a_preset_index == $past(fld_a));
  endproperty
  a_ddc_a_reg: assert property (p_ddc_a_reg)
    else $error("ddc a preset does not follow register field");

  property p_bind_b;
    wr_bind |=> (chan_b_source_select == $past(wd_bit1));
  endproperty
  a_bind_b: assert property (p_bind_b)
    else $error("channel b source not updated by write");

  property p_bind_a;
    wr_bind |=> (chan_a_source_select == $past(wd_bit0));
  endproperty
  a_bind_a: assert property (p_bind_a)
    else $error("channel a source not updated by write");

  property p_pd_a;
    1'b1 |=> (chan_a_power_down == ($past(chan_a_source_select) ?
              $past(adc_b_power_down) : $past(adc_a_power_down)));
  endproperty
  a_pd_a: assert property (p_pd_a)
    else $error("channel a power-down does not track bound adc");

  property p_div_lo;
    wr_div_lo |=> (rational_ref_divisor[7:0] == $past(wd_lo));
  endproperty
  a_div_lo: assert property (p_div_lo)
    else $error("divisor low byte not written");

  property p_ila;
    ila_fire |=> nco_phase_init;
  endproperty
  a_ila: assert property (p_ila)
    else $error("no phase start on lane-align edge");

  property p_sref;
    (sync_armed && sysref_rise && !wr_sync) |=>
      (nco_phase_init && !sync_armed);
  endproperty
  a_sref: assert property (p_sref)
    else $error("armed sysref edge did not start phase and disarm");

  property p_no_rearm;
    (!sync_armed && !ila_fire) |=> !nco_phase_init;
  endproperty
  a_no_rearm: assert property (p_no_rearm)
    else $error("phase start while not armed");

  property p_shared;
    (preset_source_mode == MODE_SHARED_PINS) |=>
      (ddc_b_preset_index == $past(pin_a));
  endproperty
  a_shared: assert property (p_shared)
    else $error("shared pin mode not applied to ddc b");

  property p_reserved;
    wr_sel |=> (nco_preset_select == $past(wd_lo));
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("preset select byte not stored whole");

  // main scenarios
  c_sref_start: cover property (sync_armed ##1 sysref_rise ##1
                                nco_phase_init);
  c_ila_start:  cover property (ila_fire ##1 nco_phase_init);
  c_pin_pairs:  cover property (preset_source_mode == MODE_PIN_PAIRS);
  c_swap_bind:  cover property (chan_a_source_select &&
                                !chan_b_source_select);

endmodule

// ### dnpbs_pkg.sv
// dnpbs_pkg: shared constants and types for the nco preset/binding/sync bank
// assumes a 32-bit apb with 12-bit byte addresses, one register per word

package dnpbs_pkg;

  // ****************************************************************
  // bus geometry
  // ****************************************************************
  localparam int ADDR_W = 12;
  localparam int IDX_W  = 10;

  // ****************************************************************
  // register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [IDX_W-1:0] IDX_PRESET_SELECT = 10'h215;
  localparam logic [IDX_W-1:0] IDX_CHAN_BIND     = 10'h216;
  localparam logic [IDX_W-1:0] IDX_REF_DIV       = 10'h217;
  localparam logic [IDX_W-1:0] IDX_PHASE_SYNC    = 10'h219;
  localparam logic [IDX_W-1:0] IDX_STATUS        = 10'h21a;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0]  RST_PRESET_SELECT = 8'h00;
  localparam logic [7:0]  RST_CHAN_BIND     = 8'h02;
  localparam logic [15:0] RST_REF_DIV       = 16'h0000;
  localparam logic [7:0]  RST_PHASE_SYNC    = 8'h02;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int DDC_A_LSB      = 0;
  localparam int DDC_B_LSB      = 2;
  localparam int BIT_CHAN_A_SRC = 0;
  localparam int BIT_CHAN_B_SRC = 1;
  localparam int BIT_SYNC_NEXT  = 0;
  localparam int BIT_SYNC_ILA   = 1;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    MODE_REGISTER    = 2'h0,
    MODE_PIN_PAIRS   = 2'h1,
    MODE_SHARED_PINS = 2'h2,
    MODE_RESERVED    = 2'h3
  } dnpbs_mode_t;

  typedef enum logic [2:0] {
    ARM_IDLE   = 3'h1,
    ARM_PRIMED = 3'h2,
    ARM_READY  = 3'h4
  } dnpbs_arm_t;

endpackage

// ### dnpbs_pin_sync.sv
// dnpbs_pin_sync: three-stage synchroniser with agreement filter per bit
// assumes inputs are asynchronous pins; output changes once stages 2 and 3
// agree, so a one-cycle glitch past stage 2 never reaches the output

`timescale 1ns/1ps

module dnpbs_pin_sync #(
  parameter int W = 1
) (
  input  wire logic         pclk,    // device clock
  input  wire logic         presetn, // async reset, active low
  input  wire logic [W-1:0] d,       // raw pin levels
  output logic      [W-1:0] q        // filtered synchronous levels
);

  // ****************************************************************
  // per-bit chain
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < W; gi++) begin : g_bit
      logic s1;
      logic s2;
      logic s3;

      // stage 1 feeds stage 2 only
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1 <= 1'b0;
          s2 <= 1'b0;
          s3 <= 1'b0;
        end else begin
          s1 <= d[gi];
          s2 <= s1;
          s3 <= s2;
        end
      end

      // accept a level only when the last two stages agree
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          q[gi] <= 1'b0;
        end else if (s2 == s3) begin
          q[gi] <= s3;
        end
      end
    end
  endgenerate

endmodule

// ### dnpbs_sysref_src.sv
// dnpbs_sysref_src: behavioural sysref source facing the register bank
// assumes pclk as timing base; fire is a one-cycle request from the bench

`timescale 1ns/1ps

module dnpbs_sysref_src (
  input  wire logic pclk,    // device clock
  input  wire logic presetn, // async reset, low
  input  wire logic fire,    // request one pulse
  output logic      sysref   // level on the sysref pin
);
  // ****************************************************************
  // pulse generator
  // ****************************************************************
  logic [2:0] cnt;

  // idle until asked
  // pulse held three cycles so the pin filter cannot drop it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 3'h0;
    end else if (fire) begin
      cnt <= 3'h3;
    end else if (cnt != 3'h0) begin
      cnt <= cnt - 3'h1;
    end
  end

  // pin low between pulses, never left floating
  assign sysref = (cnt != 3'h0);
endmodule

// ### dnpbs_tb.sv
// dnpbs_tb: self-checking bench for the nco preset/binding/sync bank
// assumes the bank answers apb in one access cycle and a sysref source

`timescale 1ns/1ps

`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin \
  err_count++; $display("mismatch t=%0t got=%h exp=%h", $time, g, e); \
  end end

module testbench;
  import dnpbs_pkg::*;
  // ****************************************************************
  // stimulus and wiring
  // ****************************************************************
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, fire = 1'b0, lmfc = 1'b0;
  logic        pd_a = 1'b0, pd_b = 1'b0, pready, pslverr, err, sysref;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0]  pstrb = 4'hf;
  logic [1:0]  mode = 2'h0, pa = 2'h0, pb = 2'h0, ia, ib;
  logic        sa, sb, cpa, cpb, init, armed;
  logic [15:0] rdiv;
  int          err_count = 0, comparisons = 0, hits;

  always #2.5 pclk = ~pclk;

  dnpbs_sysref_src u_src (.pclk(pclk), .presetn(presetn), .fire(fire),
    .sysref(sysref));

  dnpbs_regs uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .preset_source_mode(mode), .ncoa_pins(pa), .ncob_pins(pb),
    .sysref(sysref), .lmfc_ila_start(lmfc), .adc_a_power_down(pd_a),
    .adc_b_power_down(pd_b), .ddc_a_preset_index(ia),
    .ddc_b_preset_index(ib), .chan_a_source_select(sa),
    .chan_b_source_select(sb), .chan_a_power_down(cpa),
    .chan_b_power_down(cpb), .rational_ref_divisor(rdiv),
    .nco_phase_init(init), .sync_armed(armed));

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  // apb transfer; request held until pready seen at an edge
  // no cycle limit here: only the watchdog may end a wait for pready
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // count phase-start pulses over a window
  task automatic pulses(input int n);
    hits = 0;
    repeat (n) begin
      @(posedge pclk);
      if (init === 1'b1) hits++;
    end
  endtask

  task automatic sref;
    @(posedge pclk) fire <= 1'b1;
    @(posedge pclk) fire <= 1'b0;
    pulses(12);
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset;
    apb(1'b0, 12'h854, 32'h0); `CHK(rd, 32'h0)
    apb(1'b0, 12'h858, 32'h0); `CHK(rd, 32'h2)
    apb(1'b0, 12'h85c, 32'h0); `CHK(rd, 32'h0)
    apb(1'b0, 12'h864, 32'h0); `CHK(rd, 32'h2)
    `CHK(sb, 1'b1)
    `CHK(sa, 1'b0)
  endtask

  task automatic t_preset;
    pa <= 2'h3;
    pb <= 2'h1;
    apb(1'b1, 12'h854, 32'hf9);
    repeat (2) @(posedge pclk);
    `CHK(ia, 2'h1)
    `CHK(ib, 2'h2)
    apb(1'b0, 12'h854, 32'h0); `CHK(rd, 32'hf9)
    // pins take over in modes 1 and 2, register again in mode 3
    for (int m = 1; m < 4; m++) begin
      mode <= 2'(m);
      repeat (8) @(posedge pclk);
      `CHK(ia, (m == 3) ? 2'h1 : 2'h3)
      `CHK(ib, (m == 1) ? 2'h1 : (m == 2) ? 2'h3 : 2'h2)
    end
    mode <= 2'h0;
  endtask

  task automatic t_bind;
    // link and calibration off
    // this bench never enables the link or calibration around the write
    apb(1'b1, 12'h858, 32'hfd);
    repeat (2) @(posedge pclk);
    `CHK(sa, 1'b1)
    `CHK(sb, 1'b0)
    pd_a <= 1'b1;
    repeat (3) @(posedge pclk);
    `CHK({cpa, cpb}, 2'b01)
    pd_a <= 1'b0;
    pd_b <= 1'b1;
    repeat (3) @(posedge pclk);
    `CHK({cpa, cpb}, 2'b10)
    pd_b <= 1'b0;
    apb(1'b0, 12'h858, 32'h0); `CHK(rd, 32'hfd)
    apb(1'b1, 12'h858, 32'h02);
  endtask

  task automatic t_div;
    // the write lands at the access edge; look one edge later
    apb(1'b1, 12'h85c, 32'ha5c3);
    @(posedge pclk);
    `CHK(rdiv, 16'ha5c3)
    pstrb <= 4'h1;
    apb(1'b1, 12'h85c, 32'h1234);
    @(posedge pclk);
    `CHK(rdiv, 16'ha534)
    pstrb <= 4'hf;
    apb(1'b0, 12'h860, 32'h0); `CHK(err, 1'b1)
    apb(1'b1, 12'h868, 32'h1); `CHK(err, 1'b1)
  endtask

  task automatic t_ila;
    @(posedge pclk) lmfc <= 1'b1;
    @(posedge pclk) lmfc <= 1'b0;
    pulses(4); `CHK(hits, 1)
    apb(1'b1, 12'h864, 32'h0);
    @(posedge pclk) lmfc <= 1'b1;
    @(posedge pclk) lmfc <= 1'b0;
    pulses(4); `CHK(hits, 0)
  endtask

  task automatic t_sysref;
    sref; `CHK(hits, 0)
    apb(1'b1, 12'h864, 32'h1);
    repeat (2) @(posedge pclk);
    `CHK(armed, 1'b1)
    // status: armed flag, ddc b preset 2, ddc a preset 1, no power-down
    apb(1'b0, 12'h868, 32'h0); `CHK(rd, 32'h109)
    sref; `CHK(hits, 1)
    `CHK(armed, 1'b0)
    sref; `CHK(hits, 0)
    // a one without a preceding zero must not rearm
    apb(1'b1, 12'h864, 32'h1);
    sref; `CHK(hits, 0)
    apb(1'b1, 12'h864, 32'h0);
    apb(1'b1, 12'h864, 32'h1);
    sref; `CHK(hits, 1)
  endtask

  // ****************************************************************
  // sequence, watchdog and verdict
  // ****************************************************************
  task automatic print_verdict;
    $display("comparisons=%0d err_count=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_preset;
    t_bind;
    t_div;
    t_ila;
    t_sysref;
    print_verdict;
  end

  // run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge pclk);
    err_count++;
    print_verdict;
  end
endmodule
